//--- rtl/scci_pkg.sv
// Constants and types for the card command-issue block.
// Assumes an APB master on mclk and a card clock sampled as a plain input.
// How it works
// [RULE1] Software programs transfer control before command write
// [RULE2] Transfer all length bytes, then signal completion
// [RULE3] Software keeps length a multiple of block
// [RULE4] Length field reads back bytes still remaining
// [RULE5] Data path waits for enable; bit0 direction
// [RULE6] Argument register goes out as command argument
// [RULE7] Argument reads back last written value
// [RULE8] Response format field selects expected response
// [RULE9] Data flag marks commands that move data; code only uses it to mask the line-one interrupt
// [RULE10] Data flag gates line-one interrupt in 4-bit
// [RULE11] Index bits go out as command index
// [RULE12] Command write starts the command at once
// [RULE13] Command read returns index, starts nothing
// [RULE14] Block length is two to code power
// [RULE15] Reserved bits read zero, writes ignored
`default_nettype none

package scci_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFF_CONFIG = 8'h10;
	localparam logic [7:0] OFF_XFER = 8'h14;
	localparam logic [7:0] OFF_ARG = 8'h18;
	localparam logic [7:0] OFF_CMD = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h40;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int XFER_LEN_LSB = 16;
	localparam int XFER_ENA_BIT = 1;
	localparam int XFER_DIR_BIT = 0;
	localparam int CMD_RSP_LSB = 8;
	localparam int CMD_DATA_BIT = 6;
	localparam int CFG_BLK_LSB = 0;
	localparam int CFG_WIDTH_LSB = 12;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Encodings and timing counts
	// ----------------------------------------
	localparam logic [2:0] RSP_R1 = 3'h0;
	localparam logic [2:0] RSP_R1B = 3'h1;
	localparam logic [2:0] RSP_R2 = 3'h2;
	localparam logic [2:0] RSP_R3 = 3'h3;
	localparam logic [2:0] RSP_NONE = 3'h4;
	localparam logic [1:0] WIDTH_4BIT = 2'h1;
	localparam logic [7:0] FRAME_BITS = 8'h30;
	localparam logic [7:0] LONG_RSP_BITS = 8'h88;
	localparam logic [6:0] NCR_EDGES = 7'h40;

	typedef enum {
		ST_IDLE, ST_CMD, ST_RSP_WAIT, ST_RSP, ST_BUSY, ST_DSTART, ST_DBITS, ST_DEND, ST_DGAP
	} scci_state_type;

	typedef struct packed {
		logic cmd_out;
		logic cmd_oe;
		logic [3:0] dat_out;
		logic [3:0] dat_oe;
	} scci_card_out_type;

endpackage

`default_nettype wire

//--- rtl/scci_command_issue.sv
// Command issue and data path control for a memory card host.
// Assumes APB on mclk; card clock, command and data lines arrive asynchronously.
`default_nettype none

module scci_command_issue (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic card_clk,
	input wire logic card_cmd_in,
	input wire logic [3:0] card_data_in,
	output scci_pkg::scci_card_out_type card_out,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic cmd_done,
	output logic xfer_done,
	output logic sdio_irq
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [6:0] scci_crc7(input logic [39:0] d);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c = {c[5:0], 1'b0};
			if (fb) begin
				c = c ^ 7'h09;
			end
		end
		return c;
	endfunction

	function automatic logic [16:0] scci_blk_bytes(input logic [3:0] code);
		return 17'h0_0001 << code;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic clk_d;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 6'h3E;
			sync2 <= 6'h3E;
			clk_d <= 1'b0;
		end else begin
			sync1 <= {card_data_in, card_cmd_in, card_clk};
			sync2 <= sync1;
			clk_d <= sync2[0];
		end
	end

	wire link_rise = sync2[0] & ~clk_d;
	wire link_fall = ~sync2[0] & clk_d;
	wire cmd_line = sync2[1];
	wire [3:0] dat_line = sync2[5:2];
	wire card_line_one = dat_line[1];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [3:0] cfg_blk;
	logic [1:0] cfg_width;
	logic [15:0] remaining;
	logic xfer_ena;
	logic xfer_dir;
	logic [31:0] arg;
	logic [5:0] cmd_idx;
	logic [2:0] cmd_rsp;
	logic cmd_data;
	logic rsp_timeout;
	scci_pkg::scci_state_type state;

	wire commit = psel & penable & pready;
	wire wr_commit = commit & pwrite;
	wire sel_cfg = paddr == scci_pkg::OFF_CONFIG;
	wire sel_xfer = paddr == scci_pkg::OFF_XFER;
	wire sel_arg = paddr == scci_pkg::OFF_ARG;
	wire sel_cmd = paddr == scci_pkg::OFF_CMD;
	wire sel_stat = paddr == scci_pkg::OFF_STATUS;
	wire mapped = sel_cfg | sel_xfer | sel_arg | sel_cmd | sel_stat;
	wire cmd_write = wr_commit & sel_cmd; // see [RULE12]
	wire xfer_write = wr_commit & sel_xfer;
	wire wide = cfg_width == scci_pkg::WIDTH_4BIT;
	wire data_active = state inside {scci_pkg::ST_DSTART, scci_pkg::ST_DBITS, scci_pkg::ST_DEND, scci_pkg::ST_DGAP};
	wire busy = state != scci_pkg::ST_IDLE;

	// Reserved bits dropped on write, zero on read; see [RULE15]
	wire [31:0] rd_cfg = {18'h0_0000, cfg_width, 8'h00, cfg_blk};
	wire [31:0] rd_xfer = {remaining, 14'h0000, xfer_ena, xfer_dir}; // see [RULE4]
	wire [31:0] rd_cmd = {21'h00_0000, cmd_rsp, 1'b0, cmd_data, cmd_idx}; // see [RULE13]
	wire [31:0] rd_stat = {28'h000_0000, sdio_irq, rsp_timeout, data_active, busy};
	wire [31:0] rd_mux = sel_cfg ? rd_cfg : sel_xfer ? rd_xfer : sel_arg ? arg : sel_cmd ? rd_cmd :
		sel_stat ? rd_stat : 32'h0000_0000;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= scci_pkg::REG_RESET;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_blk <= 4'h0;
			cfg_width <= 2'h0;
			xfer_ena <= 1'b0;
			xfer_dir <= 1'b0;
			arg <= scci_pkg::REG_RESET;
			cmd_idx <= 6'h00;
			cmd_rsp <= 3'h0;
			cmd_data <= 1'b0;
		end else if (wr_commit) begin
			if (sel_cfg) begin
				cfg_blk <= pwdata[scci_pkg::CFG_BLK_LSB +: 4];
				cfg_width <= pwdata[scci_pkg::CFG_WIDTH_LSB +: 2];
			end
			if (sel_xfer) begin
				xfer_ena <= pwdata[scci_pkg::XFER_ENA_BIT];
				xfer_dir <= pwdata[scci_pkg::XFER_DIR_BIT];
			end
			if (sel_arg) begin
				arg <= pwdata; // see [RULE7]
			end
			if (sel_cmd) begin
				cmd_idx <= pwdata[5:0];
				cmd_rsp <= pwdata[scci_pkg::CMD_RSP_LSB +: 3]; // see [RULE8]
				cmd_data <= pwdata[scci_pkg::CMD_DATA_BIT]; // see [RULE9]
			end
		end
	end

	// ----------------------------------------
	// Card sequencer
	// ----------------------------------------
	logic [47:0] frame;
	logic [7:0] bit_cnt;
	logic [6:0] wait_cnt;
	logic [2:0] beat;
	logic [16:0] blk_left;
	logic [7:0] dbyte;

	// Frame takes the index from the command write data and the argument already held; see [RULE6] see [RULE11] see [RULE1]
	wire [39:0] frame_head = {2'b01, pwdata[5:0], arg};
	wire [47:0] next_frame = {frame_head, scci_crc7(frame_head), 1'b1};
	wire [2:0] last_beat = wide ? 3'h1 : 3'h7;
	wire [7:0] rsp_len = (cmd_rsp == scci_pkg::RSP_R2) ? scci_pkg::LONG_RSP_BITS : scci_pkg::FRAME_BITS;
	wire start_data = xfer_ena && remaining != 16'h0000; // see [RULE5]
	wire [7:0] wr_src = (beat == 3'h0) ? tx_byte : dbyte;
	wire [7:0] rd_next = wide ? {dbyte[3:0], dat_line} : {dbyte[6:0], dat_line[0]};
	wire [3:0] wr_lines = wide ? wr_src[7:4] : {3'h7, wr_src[7]};
	wire [7:0] wr_rest = wide ? {wr_src[3:0], 4'h0} : {wr_src[6:0], 1'b0};
	wire byte_end = remaining == 16'h0001 || blk_left == 17'h0_0001;
	wire [3:0] lane_oe = wide ? 4'hF : 4'h1;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= scci_pkg::ST_IDLE;
			frame <= 48'h0000_0000_0000;
			bit_cnt <= 8'h00;
			wait_cnt <= 7'h00;
			beat <= 3'h0;
			blk_left <= 17'h0_0000;
			dbyte <= 8'h00;
			remaining <= 16'h0000;
			rsp_timeout <= 1'b0;
			card_out <= '{cmd_out: 1'b1, cmd_oe: 1'b0, dat_out: 4'hF, dat_oe: 4'h0};
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
			cmd_done <= 1'b0;
			xfer_done <= 1'b0;
		end else begin
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			cmd_done <= 1'b0;
			xfer_done <= 1'b0;
			if (xfer_write) begin
				remaining <= pwdata[scci_pkg::XFER_LEN_LSB +: 16];
			end
			if (cmd_write) begin
				state <= scci_pkg::ST_CMD;
				frame <= next_frame;
				bit_cnt <= 8'h00;
				rsp_timeout <= 1'b0;
				card_out <= '{cmd_out: 1'b1, cmd_oe: 1'b0, dat_out: 4'hF, dat_oe: 4'h0};
			end else begin
				unique case (state)
					scci_pkg::ST_IDLE: begin
					end
					scci_pkg::ST_CMD: if (link_fall) begin
						if (bit_cnt == scci_pkg::FRAME_BITS) begin
							card_out.cmd_oe <= 1'b0;
							bit_cnt <= 8'h00;
							wait_cnt <= 7'h00;
							if (cmd_rsp == scci_pkg::RSP_NONE) begin
								cmd_done <= 1'b1;
								state <= start_data ? scci_pkg::ST_DSTART : scci_pkg::ST_IDLE;
							end else begin
								state <= scci_pkg::ST_RSP_WAIT;
							end
						end else begin
							card_out.cmd_oe <= 1'b1;
							card_out.cmd_out <= frame[47];
							frame <= {frame[46:0], 1'b1};
							bit_cnt <= bit_cnt + 8'h01;
						end
					end
					scci_pkg::ST_RSP_WAIT: if (link_rise) begin
						if (!cmd_line) begin
							bit_cnt <= 8'h01;
							state <= scci_pkg::ST_RSP;
						end else if (wait_cnt == scci_pkg::NCR_EDGES - 7'h01) begin
							rsp_timeout <= 1'b1;
							cmd_done <= 1'b1;
							state <= scci_pkg::ST_IDLE;
						end else begin
							wait_cnt <= wait_cnt + 7'h01;
						end
					end
					scci_pkg::ST_RSP: if (link_rise) begin
						bit_cnt <= bit_cnt + 8'h01;
						if (bit_cnt == rsp_len - 8'h01) begin
							if (cmd_rsp == scci_pkg::RSP_R1B) begin
								state <= scci_pkg::ST_BUSY;
							end else begin
								cmd_done <= 1'b1;
								state <= start_data ? scci_pkg::ST_DSTART : scci_pkg::ST_IDLE;
							end
						end
					end
					scci_pkg::ST_BUSY: if (link_rise && dat_line[0]) begin
						cmd_done <= 1'b1;
						state <= start_data ? scci_pkg::ST_DSTART : scci_pkg::ST_IDLE;
					end
					scci_pkg::ST_DSTART: begin
						blk_left <= scci_blk_bytes(cfg_blk); // see [RULE14]
						beat <= 3'h0;
						if (xfer_dir && link_fall) begin
							card_out.dat_oe <= lane_oe;
							card_out.dat_out <= 4'h0;
							state <= scci_pkg::ST_DBITS;
						end else if (!xfer_dir && link_rise && !dat_line[0]) begin
							state <= scci_pkg::ST_DBITS;
						end
					end
					scci_pkg::ST_DBITS: begin
						if (xfer_dir && link_fall && (beat != 3'h0 || tx_valid)) begin
							tx_ready <= beat == 3'h0;
							card_out.dat_out <= wr_lines;
							dbyte <= wr_rest;
							beat <= (beat == last_beat) ? 3'h0 : beat + 3'h1;
						end
						if (!xfer_dir && link_rise) begin
							dbyte <= rd_next;
							beat <= (beat == last_beat) ? 3'h0 : beat + 3'h1;
						end
						if (beat == last_beat && ((xfer_dir && link_fall) || (!xfer_dir && link_rise))) begin
							remaining <= remaining - 16'h0001; // see [RULE2] see [RULE4]
							blk_left <= blk_left - 17'h0_0001;
							if (!xfer_dir) begin
								rx_byte <= rd_next;
								rx_valid <= 1'b1;
							end
							if (byte_end) begin
								state <= scci_pkg::ST_DEND;
							end
						end
					end
					scci_pkg::ST_DEND: begin
						if (xfer_dir && link_fall) begin
							card_out.dat_out <= 4'hF;
							state <= scci_pkg::ST_DGAP;
						end else if (!xfer_dir && link_rise) begin
							state <= (remaining == 16'h0000) ? scci_pkg::ST_IDLE : scci_pkg::ST_DSTART;
							xfer_done <= remaining == 16'h0000;
						end
					end
					scci_pkg::ST_DGAP: if (link_fall) begin
						card_out.dat_oe <= 4'h0;
						state <= (remaining == 16'h0000) ? scci_pkg::ST_IDLE : scci_pkg::ST_DSTART;
						xfer_done <= remaining == 16'h0000;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Line-one interrupt window
	// ----------------------------------------
	// In 4-bit mode line one carries data during data commands; see [RULE10] see [RULE9]
	wire irq_window = ~wide | ~(cmd_data & data_active);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdio_irq <= 1'b0;
		end else begin
			sdio_irq <= irq_window & ~card_line_one;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_CMD_STARTS: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE12]
		cmd_write |=> state == scci_pkg::ST_CMD && bit_cnt == 8'h00)
		else $error("Command write did not start the command");

	AST_FRAME_INDEX: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE11]
		cmd_write |=> frame[45:40] == $past(pwdata[5:0]) && frame[47:46] == 2'b01)
		else $error("Command index not placed in frame");

	AST_FRAME_ARG: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE6]
		cmd_write |=> frame[39:8] == $past(arg) && frame[0])
		else $error("Argument not placed in frame");

	AST_ARG_READBACK: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE7]
		(commit && !pwrite && sel_arg) |-> prdata == arg)
		else $error("Argument read differs from last write");

	AST_CMD_READ_QUIET: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE13]
		(commit && !pwrite && sel_cmd && state == scci_pkg::ST_IDLE) |=> state == scci_pkg::ST_IDLE)
		else $error("Command read started a transfer");

	AST_DATA_NEEDS_ENA: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE5]
		$rose(data_active) |-> $past(xfer_ena) && $past(remaining) != 16'h0000)
		else $error("Data path started while disabled");

	AST_DONE_AT_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE2]
		xfer_done |-> remaining == 16'h0000 && state == scci_pkg::ST_IDLE)
		else $error("Completion before all bytes moved");

	AST_REMAIN_COUNTS: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE4]
		(rx_valid && !$past(xfer_write)) |-> remaining == $past(remaining) - 16'h0001)
		else $error("Remaining count not decremented per byte");

	AST_NO_RSP_WAIT: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE8]
		state == scci_pkg::ST_RSP_WAIT |-> cmd_rsp != scci_pkg::RSP_NONE)
		else $error("Waited for response on no-response command");

	AST_IRQ_MASKED: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE10]
		(wide && cmd_data && data_active) |=> !sdio_irq)
		else $error("Line-one interrupt seen inside data window");

	AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE15]
		(pready && !pwrite && (sel_xfer || sel_cmd)) |-> prdata[15:11] == 5'h00 && prdata[7] == 1'b0)
		else $error("Reserved bits read nonzero");

	AST_BLOCK_LEN: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE14]
		$rose(state == scci_pkg::ST_DBITS) |-> blk_left == (17'h0_0001 << cfg_blk))
		else $error("Block length not two to the code");

endmodule

`default_nettype wire

//--- tb/scci_card_model.sv
// Behavioural memory card facing the command-issue block.
// Assumes the bench gates the card clock and sets reply lengths.
`default_nettype none

module scci_card_model (
	output logic card_clk,
	output logic card_cmd_in,
	output logic [3:0] card_data_in,
	input wire scci_pkg::scci_card_out_type card_out,
	input wire logic run,
	input wire logic [7:0] rsp_bits,
	input wire logic [1:0] rd_blocks,
	input wire logic [7:0] rd_base,
	input wire logic line_one_low,
	output logic [31:0] frames,
	output logic [5:0] got_idx,
	output logic [31:0] got_arg,
	output logic [17:0] wr_bits,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [47:0] sh;
	logic [17:0] blk;
	logic oe_q;
	logic dat0;

	// ----
	// Clock while running; lines pulled up
	// ----
	initial begin
		card_clk = 1'b0;
		card_cmd_in = 1'b1;
		dat0 = 1'b1;
		oe_q = 1'b0;
		busy = 1'b0;
		frames = 32'h0000_0000;
	end
	always begin
		#160;
		if (run) card_clk = ~card_clk;
	end
	assign card_data_in = {2'b11, ~line_one_low, dat0};

	// ----
	// Command and write data capture
	// ----
	always @(posedge card_clk) begin
		oe_q <= card_out.cmd_oe;
		if (card_out.cmd_oe) sh <= {sh[46:0], card_out.cmd_out};
		if (card_out.dat_oe[0]) wr_bits <= {wr_bits[16:0], card_out.dat_out[0]};
		if (oe_q && !card_out.cmd_oe) begin
			frames <= frames + 32'h0000_0001;
			got_idx <= sh[45:40];
			got_arg <= sh[39:8];
		end
	end

	// ----
	// Reply, then two-byte read blocks
	// ----
	always @(frames) begin
		if (frames !== 32'h0000_0000) begin
			busy = 1'b1;
			repeat (2) @(negedge card_clk);
			for (int i = 0; i < rsp_bits; i++) begin
				card_cmd_in = (i == 0) ? 1'b0 : 1'b1;
				@(negedge card_clk);
			end
			card_cmd_in = 1'b1;
			for (int b = 0; b < rd_blocks; b++) begin
				blk = {1'b0, rd_base + 8'(2 * b), rd_base + 8'(2 * b + 1), 1'b1};
				repeat (2) @(negedge card_clk);
				for (int i = 17; i >= 0; i--) begin
					dat0 = blk[i];
					@(negedge card_clk);
				end
			end
			busy = 1'b0;
		end
	end
endmodule

`default_nettype wire

//--- tb/scci_command_issue_tb_top.sv
// Self-checking bench for the card command-issue block.
// Assumes the card model in tb and the design under rtl.
`default_nettype none

module scci_command_issue_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, psel, penable, pwrite, tx_valid, run, line_one_low, err, mbusy;
	logic pready, pslverr, card_clk, card_cmd_in, tx_ready, rx_valid, cmd_done, xfer_done, sdio_irq;
	logic [7:0] paddr, tx_byte, tx_next, rsp_bits, rd_base, rx_byte, b0, b1;
	logic [1:0] rd_blocks;
	logic [3:0] card_data_in;
	logic [5:0] got_idx;
	logic [17:0] wr_bits;
	logic [31:0] pwdata, prdata, q, d, c, frames, got_arg;
	logic [7:0] rx_seen [$];
	scci_pkg::scci_card_out_type card_out;
	int errors, checks_done, cycles, n_cmd, n_rx, n_tx, n_xfer, base;

	// ----
	// Instances and counters
	// ----
	scci_command_issue DUT (
		.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_clk(card_clk),
		.card_cmd_in(card_cmd_in), .card_data_in(card_data_in), .card_out(card_out), .tx_byte(tx_byte),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.cmd_done(cmd_done), .xfer_done(xfer_done), .sdio_irq(sdio_irq)
	);
	scci_card_model card (
		.card_clk(card_clk), .card_cmd_in(card_cmd_in), .card_data_in(card_data_in), .card_out(card_out),
		.run(run), .rsp_bits(rsp_bits), .rd_blocks(rd_blocks), .rd_base(rd_base), .line_one_low(line_one_low),
		.frames(frames), .got_idx(got_idx), .got_arg(got_arg), .wr_bits(wr_bits), .busy(mbusy)
	);
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cmd_done === 1'b1) n_cmd++;
		if (xfer_done === 1'b1) n_xfer++;
		if (tx_ready === 1'b1) begin
			n_tx++;
			tx_byte <= tx_next;
		end
		if (rx_valid === 1'b1) begin
			n_rx++;
			rx_seen.push_back(rx_byte);
		end
		if (cycles == 40000) begin
			errors++;
			conclude();
		end
	end

	// ----
	// Tasks and expectations
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic await_count(ref int cnt, input int target);
		while (cnt < target) @(posedge mclk);
	endtask
	task automatic issue(input logic [31:0] v);
		int n;
		n = n_cmd;
		run <= 1'b1;
		apb(1'b1, scci_pkg::OFF_CMD, v);
		await_count(n_cmd, n + 1);
	endtask
	task automatic settle();
		repeat (2) @(posedge card_clk);
		@(posedge mclk);
		while (mbusy !== 1'b0) @(posedge mclk);
	endtask
	function automatic logic [31:0] cmd_view(input logic [31:0] v);
		return v & 32'h0000_077f;
	endfunction
	function automatic logic [31:0] xfer_view(input logic [31:0] v);
		return v & 32'hffff_0003;
	endfunction
	function automatic logic [7:0] rsp_len(input logic [2:0] r);
		return (r == scci_pkg::RSP_NONE) ? 8'h00 : (r == scci_pkg::RSP_R2) ? 8'h88 : 8'h30;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end
		else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, tx_valid, run, line_one_low} = '0;
		{paddr, tx_byte, tx_next, rsp_bits, rd_base, rd_blocks, pwdata} = '0;
		void'($urandom(32'hfcba_81b0));
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		apb(1'b0, scci_pkg::OFF_ARG, 32'h0000_0000);
		check(q, 32'h0000_0000, "argument reset");
		apb(1'b0, scci_pkg::OFF_CMD, 32'h0000_0000);
		check(q, 32'h0000_0000, "command reset");
		apb(1'b0, 8'h30, 32'h0000_0000);
		check({q[30:0], err}, 32'h0000_0001, "unmapped read");
		$display("test reset done");
		repeat (4) begin
			d = $urandom;
			apb(1'b1, scci_pkg::OFF_ARG, d);
			apb(1'b0, scci_pkg::OFF_ARG, 32'h0000_0000);
			check(q, d, "argument readback");
			d = $urandom & 32'hffff_fffd;
			apb(1'b1, scci_pkg::OFF_XFER, d);
			apb(1'b0, scci_pkg::OFF_XFER, 32'h0000_0000);
			check(q, xfer_view(d), "transfer readback");
		end
		$display("test registers done");
		rd_blocks <= 2'h1;
		for (int r = 0; r < 5; r++) begin
			d = $urandom;
			c = $urandom;
			c[10:8] = 3'(r);
			rsp_bits <= rsp_len(3'(r));
			apb(1'b1, scci_pkg::OFF_ARG, d);
			issue(c);
			settle();
			check(got_idx, c[5:0], "index sent");
			check(got_arg, d, "argument sent");
			apb(1'b0, scci_pkg::OFF_CMD, 32'h0000_0000);
			check(q, cmd_view(c), "command readback");
			apb(1'b0, scci_pkg::OFF_STATUS, 32'h0000_0000);
			check(q[2], 1'b0, "reply format");
			check(frames, r + 1, "frame per write");
		end
		rsp_bits <= 8'h00;
		issue(32'h0000_0002);
		settle();
		apb(1'b0, scci_pkg::OFF_STATUS, 32'h0000_0000);
		check(q[3:0], 4'h4, "reply timeout");
		check(n_rx + n_xfer, 0, "data while disabled");
		$display("test commands done");
		apb(1'b1, scci_pkg::OFF_CONFIG, 32'h0000_0001);
		apb(1'b1, scci_pkg::OFF_XFER, 32'h0004_0002);
		rd_base <= 8'($urandom);
		rd_blocks <= 2'h2;
		rsp_bits <= 8'h30;
		line_one_low <= 1'b1;
		issue(32'h0000_0051);
		await_count(n_rx, 1);
		apb(1'b0, scci_pkg::OFF_XFER, 32'h0000_0000);
		check(q[31:16], 16'h0003, "remaining mid-read");
		check(sdio_irq, 1'b1, "line one, 1-bit");
		settle();
		await_count(n_xfer, 1);
		check(n_rx, 4, "bytes read");
		foreach (rx_seen[i]) check(rx_seen[i], 8'(rd_base + 8'(i)), "read data");
		apb(1'b0, scci_pkg::OFF_XFER, 32'h0000_0000);
		check(q, 32'h0000_0002, "remaining after read");
		$display("test read done");
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		apb(1'b1, scci_pkg::OFF_XFER, 32'h0002_0003);
		rd_blocks <= 2'h0;
		tx_byte <= b0;
		tx_next <= b1;
		tx_valid <= 1'b1;
		issue(32'h0000_0058);
		await_count(n_xfer, 2);
		tx_valid <= 1'b0;
		repeat (2) @(posedge card_clk);
		@(posedge mclk);
		check(n_tx, 2, "bytes taken");
		check(wr_bits, {1'b0, b0, b1, 1'b1}, "write frame");
		$display("test write done");
		line_one_low <= 1'b0;
		repeat (8) @(posedge mclk);
		check(sdio_irq, 1'b0, "line one high");
		apb(1'b1, scci_pkg::OFF_CONFIG, 32'h0000_1001);
		line_one_low <= 1'b1;
		repeat (8) @(posedge mclk);
		check(sdio_irq, 1'b1, "4-bit idle window");
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, scci_pkg::OFF_XFER, 32'h0002_0003);
			tx_byte <= b0;
			tx_next <= b1;
			tx_valid <= 1'b1;
			base = n_tx;
			issue((f != 0) ? 32'h0000_0018 : 32'h0000_0058);
			await_count(n_tx, base + 1);
			check(sdio_irq, f, "4-bit data window");
			await_count(n_xfer, 3 + f);
			tx_valid <= 1'b0;
			repeat (2) @(posedge card_clk);
			@(posedge mclk);
			check(wr_bits[5:0], {1'b0, b0[4], b0[0], b1[4], b1[0], 1'b1}, "4-bit write lanes");
		end
		$display("test interrupt done");
		conclude();
	end
endmodule

`default_nettype wire
